/* logic/rrf_pkg.sv */
// Shared constants for the receiver record output framer
`default_nettype none
package rrf_pkg;
  // Clock and time base
  localparam int          CLK_HZ             = 125000000;
  localparam int          HALF_SEC_MS        = 500;
  localparam int          HALF_SEC_CYCLES    = CLK_HZ / 1000 * HALF_SEC_MS;
  localparam int          DEFAULT_BAUD       = 9600;
  localparam logic [15:0] BAUD_DIV_RESET     = 16'(CLK_HZ / DEFAULT_BAUD);
  localparam logic [15:0] BAUD_DIV_MIN       = 16'h0002;
  // Send interval in half seconds: 0.5 s .. 999.5 s, 5 s after reset
  localparam logic [10:0] INTERVAL_MIN       = 11'h001;
  localparam logic [10:0] INTERVAL_MAX       = 11'h7cf;
  localparam logic [10:0] INTERVAL_RESET     = 11'h00a;
  // Record layout
  localparam int          HEADER_BYTES       = 11;
  localparam int          POS_PAYLOAD_BYTES  = 54;
  localparam int          EPH_PAYLOAD_BYTES  = 130;
  localparam int          POS_TOTAL_BYTES    = 69;
  localparam int          EPH_TOTAL_BYTES    = 145;
  localparam int          EPH_RECORDS        = 32;
  localparam logic [7:0]  EPH_OFF_INDEX      = 8'h80;
  localparam logic [7:0]  EPH_OFF_RSVD       = 8'h81;
  localparam logic [87:0] POS_HEADER_TEXT    = 88'h24_50_41_53_48_52_2c_50_42_4e_2c;
  localparam logic [87:0] EPH_HEADER_TEXT    = 88'h24_50_41_53_48_52_2c_53_4e_56_2c;
  localparam logic [7:0]  CHAR_CR            = 8'h0d;
  localparam logic [7:0]  CHAR_LF            = 8'h0a;
  localparam logic [7:0]  CHAR_COMMA         = 8'h2c;
  localparam logic [7:0]  CHAR_DOLLAR        = 8'h24;
  localparam logic [15:0] TALKER_ID          = 16'h4750;
  // Payload memory: 33 words per record, records 0..31 ephemeris, 32 position
  localparam int          REC_WORDS          = 33;
  localparam int          MEM_WORDS          = 33 * REC_WORDS;
  localparam logic [5:0]  POS_SLOT           = 6'h20;
  localparam logic [11:0] MEM_BASE_WORD      = 12'h400;
  // Register byte offsets
  localparam logic [7:0]  REG_CTRL           = 8'h00;
  localparam logic [7:0]  REG_STATUS         = 8'h04;
  localparam logic [7:0]  REG_INTERVAL       = 8'h08;
  localparam logic [7:0]  REG_DUE            = 8'h0c;
  localparam logic [7:0]  REG_PORT_CFG       = 8'h10;
  localparam logic [7:0]  REG_PORT_TX        = 8'h20;
  // Sentence command codes in port transmit writes, bits 9:8
  localparam logic [1:0]  CMD_CHAR           = 2'h0;
  localparam logic [1:0]  CMD_EMPTY_FIELD    = 2'h1;
  localparam logic [1:0]  CMD_START          = 2'h2;
  localparam logic [1:0]  CMD_END            = 2'h3;
  localparam logic [1:0]  HTRANS_NONSEQ      = 2'h2;
  localparam logic [2:0]  HSIZE_WORD         = 3'h2;
  localparam logic [3:0]  UART_FRAME_BITS    = 4'ha;
  typedef enum logic [2:0] {
    FR_IDLE = 3'b000,
    FR_HDR  = 3'b001,
    FR_PAY  = 3'b010,
    FR_SUMH = 3'b011,
    FR_SUML = 3'b100,
    FR_CR   = 3'b101,
    FR_LF   = 3'b110
  } rrf_fr_state_t;
endpackage
`default_nettype wire

/* logic/rrf_framer.sv */
// Record framer with AHB-Lite registers and four sentence serial ports
// Overview of operation
// - Position record opens with 11-byte header then 4-byte millisecond time.
// - Four-character operator station label follows the receive time.
// - Station X, Y, Z follow as 8-byte doubles in that order.
// - Clock offset, three velocities, clock drift follow as 4-byte floats.
// - Two-byte dilution, then 16-bit checksum of words from time to dilution.
// - One position record per epoch, ended by CR LF, 69 bytes total.
// - Ephemeris goes out binary only, 32 records each with 11-byte header.
// - Mean anomaly correction, then anomaly, eccentricity, root axis as doubles.
// - Six harmonic corrections as floats in the fixed cosine/sine order.
// - Node longitude, perigee, inclination doubles, then two rate floats.
// - Accuracy, health, fit words, satellite index minus one, reserved byte.
// - Ephemeris checksum over week count to reserved, then CR LF, 145 bytes.
// - Sentences may go on any of four ports, any format mix per port.
// - Sentence period programmable 0.5 to 999.5 s in half-second steps.
// - Sentence period is five seconds after reset.
// - Serial characters use eight data bits, one stop bit, no parity.
// - Per-port sentence selection, one common period for all ports.
// - Sentences are ASCII characters with comma-separated fields.
// - An unavailable field is sent empty, giving two adjacent commas.
// - Each sentence starts with talker id and three-character type.
// - Each port has its own enable, baud rate and per-format selection.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module rrf_framer
  import rrf_pkg::*;
#(
  parameter int NUM_PORTS       = 4,
  parameter int HALF_SEC_CYCLES_P = HALF_SEC_CYCLES
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire logic                 epoch_strobe,
  output logic [7:0]                rec_data,
  output logic                      rec_valid,
  input  wire logic                 rec_ready,
  output logic [NUM_PORTS-1:0]      txd
);

  if (NUM_PORTS < 1 || NUM_PORTS > 4) begin : g_bad_ports
    $error("NUM_PORTS must be 1 to 4");
  end
  if (HALF_SEC_CYCLES_P < 2) begin : g_bad_half
    $error("HALF_SEC_CYCLES_P must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY

  logic                 wr_pend_reg;
  logic [31:0]          wr_addr_reg;
  logic [31:0]          hrdata_reg;
  logic [31:0]          rd_mux;
  logic                 addr_phase;
  logic                 bus_wr;
  logic [11:0]          bus_widx;
  logic                 bus_in_mem;
  logic [11:0]          wr_widx;
  logic                 wr_in_mem;
  logic                 wr_in_regs;

  logic [31:0]          mem [0:MEM_WORDS-1];

  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_reg;
  assign addr_phase = hsel && hready && htrans == HTRANS_NONSEQ;
  assign bus_widx   = haddr[13:2] - MEM_BASE_WORD;
  assign bus_in_mem = haddr[31:14] == '0 && haddr[13:2] >= MEM_BASE_WORD
                      && bus_widx < 12'(MEM_WORDS);
  assign wr_widx    = wr_addr_reg[13:2] - MEM_BASE_WORD;
  assign wr_in_mem  = wr_addr_reg[31:14] == '0 && wr_addr_reg[13:2] >= MEM_BASE_WORD
                      && wr_widx < 12'(MEM_WORDS);
  assign wr_in_regs = wr_addr_reg[31:8] == '0;
  assign bus_wr     = wr_pend_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= addr_phase && hwrite && hsize == HSIZE_WORD;
      if (addr_phase) begin
        wr_addr_reg <= haddr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= '0;
    end else if (addr_phase && !hwrite) begin
      hrdata_reg <= rd_mux;
    end
  end

  // Payload memory; software places field bytes in send order, big-endian
  always_ff @(posedge hclk) begin
    if (bus_wr && wr_in_mem) begin
      mem[wr_widx[10:0]] <= hwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [10:0]          interval_reg;
  logic                 pos_pend_reg;
  logic                 eph_pend_reg;
  logic                 port_en_reg  [NUM_PORTS];
  logic [7:0]           port_mask_reg[NUM_PORTS];
  logic [15:0]          port_div_reg [NUM_PORTS];
  logic [NUM_PORTS-1:0] due_reg;
  logic [NUM_PORTS-1:0] port_busy;
  logic                 ctrl_wr;
  logic                 due_wr;
  logic                 period_pulse;
  logic                 pos_take;
  logic                 eph_take;
  rrf_fr_state_t        fr_state_reg;
  logic [5:0]           fr_rec_reg;

  assign ctrl_wr = bus_wr && wr_in_regs && wr_addr_reg[7:0] == REG_CTRL;
  assign due_wr  = bus_wr && wr_in_regs && wr_addr_reg[7:0] == REG_DUE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interval_reg <= INTERVAL_RESET;
    end else if (bus_wr && wr_in_regs && wr_addr_reg[7:0] == REG_INTERVAL) begin
      // Out-of-range periods are clamped rather than refused
      if (hwdata[31:11] != '0 || hwdata[10:0] > INTERVAL_MAX) begin
        interval_reg <= INTERVAL_MAX;
      end else if (hwdata[10:0] < INTERVAL_MIN) begin
        interval_reg <= INTERVAL_MIN;
      end else begin
        interval_reg <= hwdata[10:0];
      end
    end
  end

  // A request arriving in the cycle its pending flag is taken is kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_pend_reg <= 1'b0;
      eph_pend_reg <= 1'b0;
    end else begin
      pos_pend_reg <= (pos_pend_reg && !pos_take) || epoch_strobe
                      || (ctrl_wr && hwdata[0]);
      eph_pend_reg <= (eph_pend_reg && !eph_take) || (ctrl_wr && hwdata[1]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        port_en_reg[p]   <= 1'b0;
        port_mask_reg[p] <= '0;
        port_div_reg[p]  <= BAUD_DIV_RESET;
      end
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (bus_wr && wr_in_regs && wr_addr_reg[7:0] == REG_PORT_CFG + 8'(4 * p)) begin
          port_en_reg[p]   <= hwdata[0];
          port_mask_reg[p] <= hwdata[15:8];
          port_div_reg[p]  <= hwdata[31:16] < BAUD_DIV_MIN ? BAUD_DIV_MIN : hwdata[31:16];
        end
      end
    end
  end

  // Due flags: set wins over a write-one clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      due_reg <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (period_pulse && port_en_reg[p] && port_mask_reg[p] != '0) begin
          due_reg[p] <= 1'b1;
        end else if (due_wr && hwdata[p]) begin
          due_reg[p] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    rd_mux = '0;
    if (bus_in_mem) begin
      rd_mux = mem[bus_widx[10:0]];
    end else if (haddr[31:8] == '0) begin
      if (haddr[7:0] == REG_STATUS) begin
        rd_mux[0]    = fr_state_reg != FR_IDLE;
        rd_mux[1]    = pos_pend_reg;
        rd_mux[2]    = eph_pend_reg;
        rd_mux[13:8] = fr_rec_reg;
      end
      if (haddr[7:0] == REG_INTERVAL) begin
        rd_mux[10:0] = interval_reg;
      end
      if (haddr[7:0] == REG_DUE) begin
        rd_mux[NUM_PORTS-1:0]   = due_reg;
        rd_mux[NUM_PORTS+3:4]   = port_busy;
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (haddr[7:0] == REG_PORT_CFG + 8'(4 * p)) begin
          rd_mux = {port_div_reg[p], port_mask_reg[p], 7'h00, port_en_reg[p]};
        end
        if (haddr[7:0] == REG_PORT_TX + 8'(4 * p)) begin
          rd_mux[0] = port_busy[p];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Common sentence period: half-second ticks counted up to the interval

  logic [31:0]          half_cnt_reg;
  logic [10:0]          tick_cnt_reg;
  logic                 half_tick;

  assign half_tick    = half_cnt_reg == 32'(HALF_SEC_CYCLES_P - 1);
  assign period_pulse = half_tick && tick_cnt_reg >= interval_reg - 11'h001;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_cnt_reg <= '0;
      tick_cnt_reg <= '0;
    end else begin
      half_cnt_reg <= half_tick ? '0 : half_cnt_reg + 32'h1;
      if (period_pulse) begin
        tick_cnt_reg <= '0;
      end else if (half_tick) begin
        tick_cnt_reg <= tick_cnt_reg + 11'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Record framer: header, payload, checksum word, CR LF

  logic [7:0]           fr_idx_reg;
  logic                 fr_eph_reg;
  logic [15:0]          fr_sum_reg;
  logic [87:0]          hdr_sh_reg;
  logic                 rec_valid_reg;
  logic [7:0]           rec_data_reg;
  logic                 adv;
  logic                 emit;
  logic [10:0]          pay_widx;
  logic [31:0]          pay_word;
  logic [7:0]           pay_byte;
  logic [7:0]           pay_last;
  logic [15:0]          pay_addend;
  logic [7:0]           cur_byte;

  assign adv       = !rec_valid_reg || rec_ready;
  assign emit      = adv && fr_state_reg != FR_IDLE;
  assign pos_take  = fr_state_reg == FR_IDLE && pos_pend_reg;
  assign eph_take  = fr_state_reg == FR_IDLE && !pos_pend_reg && eph_pend_reg;
  assign pay_widx  = {fr_rec_reg, 5'h00} + {5'h00, fr_rec_reg} + {5'h00, fr_idx_reg[7:2]};
  assign pay_word  = mem[pay_widx];
  assign pay_last  = fr_eph_reg ? 8'(EPH_PAYLOAD_BYTES - 1) : 8'(POS_PAYLOAD_BYTES - 1);
  assign rec_valid = rec_valid_reg;
  assign rec_data  = rec_data_reg;

  always_comb begin
    unique case (fr_idx_reg[1:0])
      2'h0: pay_byte = pay_word[31:24];
      2'h1: pay_byte = pay_word[23:16];
      2'h2: pay_byte = pay_word[15:8];
      2'h3: pay_byte = pay_word[7:0];
    endcase
    // Record number doubles as satellite number minus one
    if (fr_eph_reg && fr_idx_reg == EPH_OFF_INDEX) begin
      pay_byte = {2'h0, fr_rec_reg};
    end else if (fr_eph_reg && fr_idx_reg == EPH_OFF_RSVD) begin
      pay_byte = 8'h00;
    end
    // Even bytes are the high half of each summed word
    pay_addend = fr_idx_reg[0] ? {8'h00, pay_byte} : {pay_byte, 8'h00};
  end

  always_comb begin
    cur_byte = 8'h00;
    unique case (fr_state_reg)
      FR_IDLE: cur_byte = 8'h00;
      FR_HDR:  cur_byte = hdr_sh_reg[87:80];
      FR_PAY:  cur_byte = pay_byte;
      FR_SUMH: cur_byte = fr_sum_reg[15:8];
      FR_SUML: cur_byte = fr_sum_reg[7:0];
      FR_CR:   cur_byte = CHAR_CR;
      FR_LF:   cur_byte = CHAR_LF;
      default: cur_byte = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fr_state_reg <= FR_IDLE;
      fr_idx_reg   <= '0;
      fr_eph_reg   <= 1'b0;
      fr_rec_reg   <= '0;
      fr_sum_reg   <= '0;
      hdr_sh_reg   <= '0;
    end else begin
      unique case (fr_state_reg)
        FR_IDLE: begin
          fr_idx_reg <= '0;
          fr_sum_reg <= '0;
          if (pos_take) begin
            fr_state_reg <= FR_HDR;
            fr_eph_reg   <= 1'b0;
            fr_rec_reg   <= POS_SLOT;
            hdr_sh_reg   <= POS_HEADER_TEXT;
          end else if (eph_take) begin
            fr_state_reg <= FR_HDR;
            fr_eph_reg   <= 1'b1;
            fr_rec_reg   <= '0;
            hdr_sh_reg   <= EPH_HEADER_TEXT;
          end
        end
        FR_HDR: if (adv) begin
          hdr_sh_reg <= {hdr_sh_reg[79:0], 8'h00};
          fr_idx_reg <= fr_idx_reg == 8'(HEADER_BYTES - 1) ? 8'h00 : fr_idx_reg + 8'h01;
          if (fr_idx_reg == 8'(HEADER_BYTES - 1)) begin
            fr_state_reg <= FR_PAY;
          end
        end
        FR_PAY: if (adv) begin
          fr_sum_reg <= fr_sum_reg + pay_addend;
          fr_idx_reg <= fr_idx_reg + 8'h01;
          if (fr_idx_reg == pay_last) begin
            fr_state_reg <= FR_SUMH;
          end
        end
        FR_SUMH: if (adv) begin
          fr_state_reg <= FR_SUML;
        end
        FR_SUML: if (adv) begin
          fr_state_reg <= FR_CR;
        end
        FR_CR: if (adv) begin
          fr_state_reg <= FR_LF;
        end
        FR_LF: if (adv) begin
          fr_idx_reg <= '0;
          fr_sum_reg <= '0;
          // Ephemeris set runs all records back to back
          if (fr_eph_reg && fr_rec_reg != 6'(EPH_RECORDS - 1)) begin
            fr_rec_reg   <= fr_rec_reg + 6'h01;
            hdr_sh_reg   <= EPH_HEADER_TEXT;
            fr_state_reg <= FR_HDR;
          end else begin
            fr_state_reg <= FR_IDLE;
          end
        end
        default: fr_state_reg <= FR_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rec_valid_reg <= 1'b0;
      rec_data_reg  <= '0;
    end else begin
      rec_valid_reg <= emit || (rec_valid_reg && !rec_ready);
      if (emit) begin
        rec_data_reg <= cur_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sentence ports: small command queue feeding an 8N1 transmitter

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [47:0] q_reg;
    logic [2:0]  q_cnt_reg;
    logic [9:0]  sh_reg;
    logic [3:0]  bit_cnt_reg;
    logic [15:0] baud_cnt_reg;
    logic        cmd_wr;

    // Commands arriving while busy are dropped; software polls busy first
    assign cmd_wr       = bus_wr && wr_in_regs && wr_addr_reg[7:0] == REG_PORT_TX + 8'(4 * p)
                          && port_en_reg[p] && q_cnt_reg == '0 && bit_cnt_reg == '0;
    assign port_busy[p] = q_cnt_reg != '0 || bit_cnt_reg != '0;
    assign txd[p]       = sh_reg[0];

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        q_reg        <= '0;
        q_cnt_reg    <= '0;
        sh_reg       <= '1;
        bit_cnt_reg  <= '0;
        baud_cnt_reg <= '0;
      end else if (cmd_wr) begin
        unique case (hwdata[9:8])
          CMD_CHAR: begin
            q_reg     <= {hwdata[7:0], 40'h0};
            q_cnt_reg <= 3'h1;
          end
          CMD_EMPTY_FIELD: begin
            q_reg     <= {CHAR_COMMA, CHAR_COMMA, 32'h0};
            q_cnt_reg <= 3'h2;
          end
          CMD_START: begin
            q_reg     <= {CHAR_DOLLAR, TALKER_ID, hwdata[23:0]};
            q_cnt_reg <= 3'h6;
          end
          CMD_END: begin
            q_reg     <= {CHAR_CR, CHAR_LF, 32'h0};
            q_cnt_reg <= 3'h2;
          end
        endcase
      end else if (bit_cnt_reg == '0) begin
        if (q_cnt_reg != '0) begin
          sh_reg       <= {1'b1, q_reg[47:40], 1'b0};
          q_reg        <= {q_reg[39:0], 8'h00};
          q_cnt_reg    <= q_cnt_reg - 3'h1;
          bit_cnt_reg  <= UART_FRAME_BITS;
          baud_cnt_reg <= port_div_reg[p] - 16'h0001;
        end
      end else if (baud_cnt_reg == '0) begin
        sh_reg       <= {1'b1, sh_reg[9:1]};
        bit_cnt_reg  <= bit_cnt_reg - 4'h1;
        baud_cnt_reg <= port_div_reg[p] - 16'h0001;
      end else begin
        baud_cnt_reg <= baud_cnt_reg - 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

/* test/rrf_framer_assertions.sv */
// Checker for the record stream and bus replies of the framer
`timescale 1ns/10ps
`default_nettype none
module rrf_framer_chk
  import rrf_pkg::*;
#(
  parameter int NUM_PORTS         = 4,
  parameter int HALF_SEC_CYCLES_P = 20
) (
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire logic [7:0]           rec_data,
  input wire logic                 rec_valid,
  input wire logic                 rec_ready,
  input wire logic [NUM_PORTS-1:0] txd
);
  logic       tk;
  logic       eph;
  logic [7:0] cnt;
  logic [7:0] last;
  logic [7:0] hb;
  logic [4:0] num;
  assign tk   = rec_valid && rec_ready;
  assign last = eph ? 8'h90 : 8'h44;
  assign hb   = 8'((eph ? EPH_HEADER_TEXT : POS_HEADER_TEXT) >> (80 - 8 * int'(cnt)));
  ////////////////////////////////////////
  // Record type is known only from header byte 7, so earlier bytes match either text
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 8'h00;
      eph <= 1'b0;
      num <= 5'h00;
    end else if (tk) begin
      cnt <= (cnt == last) ? 8'h00 : cnt + 8'h01;
      if (cnt == 8'h07) eph <= (rec_data == EPH_HEADER_TEXT[31:24]);
      if (cnt == last && eph) num <= num + 5'h01;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus reply not okay");
  chk_byte_hold: assert property (
    rec_valid && !rec_ready |=> rec_valid && $stable(rec_data)) else $error("byte dropped");
  chk_header_text: assert property (
    tk && cnt < 8'h0b && cnt != 8'h07 |-> rec_data == hb) else $error("header byte wrong");
  chk_tail_cr: assert property (
    tk && cnt == last - 8'h01 |-> rec_data == CHAR_CR) else $error("no carriage return");
  chk_tail_lf: assert property (
    tk && cnt == last |-> rec_data == CHAR_LF) else $error("no line feed");
  chk_sat_index: assert property (
    tk && eph && cnt == 8'h8b |-> rec_data == {3'h0, num}) else $error("index byte wrong");
  chk_rsvd_zero: assert property (
    tk && eph && cnt == 8'h8c |-> rec_data == 8'h00) else $error("reserved byte set");
  chk_idle_high: assert property (
    $rose(hresetn) |-> &txd && !rec_valid) else $error("lines not idle after reset");
  chk_byte_flow: assert property (
    tk && cnt != last |-> ##[1:3] rec_valid) else $error("record stalled");
  cover property (tk && cnt == last && eph);
  cover property (tk && cnt == last && !eph);
  cover property ($fell(txd[0]));
endmodule
bind rrf_framer rrf_framer_chk #(.NUM_PORTS(NUM_PORTS), .HALF_SEC_CYCLES_P(HALF_SEC_CYCLES_P))
  i_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .rec_data(rec_data), .rec_valid(rec_valid), .rec_ready(rec_ready), .txd(txd));
`default_nettype wire

/* test/rrf_host_model.sv */
// Host model: takes record bytes and decodes one serial line
`timescale 1ns/10ps
`default_nettype none
module rrf_host_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        slow,
  input  wire logic [7:0]  rec_data,
  input  wire logic        rec_valid,
  input  wire logic        rxd,
  input  wire logic [15:0] div,
  output logic             rec_ready
);
  logic [7:0] rec_q[$];
  logic [7:0] chr_q[$];
  logic [1:0] ph = 2'h0;
  initial rec_ready = 1'b0;
  // Slow mode stalls two beats of three to make bytes wait
  always @(posedge hclk) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    rec_ready <= hresetn && (!slow || ph == 2'h0);
    if (rec_valid && rec_ready) rec_q.push_back(rec_data);
  end
  initial forever begin : rx
    logic [7:0] c;
    @(negedge rxd);
    repeat (div / 2) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge hclk);
      c[i] = rxd;
    end
    repeat (div) @(posedge hclk);
    if (rxd === 1'b1) chr_q.push_back(c);
  end
endmodule
`default_nettype wire

/* test/rrf_framer_test.sv */
// Self-checking bench for the receiver record output framer
`timescale 1ns/10ps
`default_nettype none
module rrf_framer_test
  import rrf_pkg::*;
;
  localparam int DIV = 4;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        epoch_strobe = 1'b0, slow = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic        hreadyout, hresp, rec_valid, rec_ready;
  logic [7:0]  rec_data;
  logic [3:0]  txd;
  logic [31:0] iv[4] = '{32'h0, 32'h800, 32'h7cf, 32'h3};
  logic [31:0] ie[4] = '{32'h1, 32'h7cf, 32'h7cf, 32'h3};
  logic [31:0] cmd[4] = '{32'h474e53, 32'h41, 32'h100, 32'h300};
  string       ch = "$GPGNSA,,\015\012";
  int          fail_count = 0, tests_run = 0, cyc = 0;
  always #4 hclk = ~hclk;
  rrf_framer #(.NUM_PORTS(4), .HALF_SEC_CYCLES_P(20)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .epoch_strobe(epoch_strobe), .rec_data(rec_data),
    .rec_valid(rec_valid), .rec_ready(rec_ready), .txd(txd));
  rrf_host_model i_host (.hclk(hclk), .hresetn(hresetn), .slow(slow), .rec_data(rec_data),
    .rec_valid(rec_valid), .rxd(txd[0]), .div(16'(DIV)), .rec_ready(rec_ready));
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel <= 1'b1; htrans <= HTRANS_NONSEQ; haddr <= a; hwrite <= w; hsize <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string what, input logic [31:0] a, exp);
    bus(1'b0, a, 32'h0, q);
    check(what, q, exp);
  endtask
  task automatic strobe();
    epoch_strobe <= 1'b1;
    @(posedge hclk);
    epoch_strobe <= 1'b0;
    @(posedge hclk);
  endtask
  function automatic logic [7:0] pb(input int r, input int k);
    return 8'(r * 7 + k * 3 + 1);
  endfunction
  // Expected record is rebuilt from the header text, the payload pattern and the record number
  task automatic take_rec(input int r, input int n);
    logic [7:0]  e[$];
    logic [7:0]  b;
    logic [15:0] s;
    s = 16'h0000;
    for (int i = 0; i < 11; i++)
      e.push_back(8'((r == 32 ? POS_HEADER_TEXT : EPH_HEADER_TEXT) >> (80 - 8 * i)));
    for (int k = 0; k < n; k++) begin
      b = (r < 32 && k > 127) ? ((k == 128) ? 8'(r) : 8'h00) : pb(r, k);
      e.push_back(b);
      s += k[0] ? {8'h00, b} : {b, 8'h00};
    end
    e.push_back(s[15:8]); e.push_back(s[7:0]); e.push_back(CHAR_CR); e.push_back(CHAR_LF);
    while (i_host.rec_q.size() < e.size()) @(posedge hclk);
    foreach (e[i]) check("record byte", 32'(i_host.rec_q.pop_front()), 32'(e[i]));
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd("interval", 32'(REG_INTERVAL), 32'(INTERVAL_RESET));
    rd("port config", 32'(REG_PORT_CFG), {BAUD_DIV_RESET, 16'h0000});
    rd("unmapped", 32'h0000_00f0, 32'h0);
    foreach (iv[i]) begin
      wr(32'(REG_INTERVAL), iv[i]);
      rd("interval", 32'(REG_INTERVAL), ie[i]);
    end
    $display("test registers done");
    for (int r = 0; r < 33; r++)
      for (int w = 0; w < 33; w++)
        wr(32'h1000 + 132 * r + 4 * w, {pb(r, 4*w), pb(r, 4*w+1), pb(r, 4*w+2), pb(r, 4*w+3)});
    strobe();
    take_rec(32, 54);
    slow <= 1'b1;
    strobe();
    repeat (20) @(posedge hclk);
    strobe();
    strobe();
    take_rec(32, 54);
    take_rec(32, 54);
    repeat (300) @(posedge hclk);
    check("extra records", 32'(i_host.rec_q.size()), 32'h0);
    $display("test position records done");
    wr(32'(REG_CTRL), 32'h2);
    for (int r = 0; r < 32; r++) take_rec(r, 130);
    $display("test ephemeris set done");
    slow <= 1'b0;
    wr(32'(REG_PORT_CFG), {16'(DIV), 16'h0101});
    wr(32'(REG_PORT_CFG) + 4, {16'(DIV), 16'h0201});
    wr(32'(REG_PORT_CFG) + 8, {16'(DIV), 16'h0001});
    foreach (cmd[i]) begin
      wr(32'(REG_PORT_TX), cmd[i]);
      repeat (2) @(posedge hclk);
      do bus(1'b0, 32'(REG_PORT_TX), 32'h0, q); while (q[0] !== 1'b0);
    end
    wr(32'(REG_PORT_TX) + 12, 32'h41);
    repeat (2) @(posedge hclk);
    rd("disabled port busy", 32'(REG_PORT_TX) + 12, 32'h0);
    check("disabled port line", 32'(txd[3]), 32'h1);
    repeat (10) @(posedge hclk);
    for (int i = 0; i < 11; i++)
      check("serial char", 32'(i_host.chr_q[i]), 32'(ch[i]));
    $display("test serial ports done");
    wr(32'(REG_INTERVAL), 32'h64);
    wr(32'(REG_DUE), 32'hf);
    repeat (2100) @(posedge hclk);
    rd("due flags", 32'(REG_DUE), 32'h3);
    wr(32'(REG_DUE), 32'hf);
    rd("due cleared", 32'(REG_DUE), 32'h0);
    $display("test send interval done");
    give_verdict();
  end
endmodule
`default_nettype wire
